// ### tws_consts.vh
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// device address word layout
`define TWS_TYPE_CODE 5'h14
`define TWS_TYPE_MSB 7
`define TWS_TYPE_LSB 3
`define TWS_SEL_HIGH_BIT 2
`define TWS_SEL_LOW_BIT 1
`define TWS_RW_BIT 0

// word address and page geometry
`define TWS_ADDR_W 15
`define TWS_PAGE_W 6
`define TWS_PAGE_BYTES 7'h40
`define TWS_HI_BYTE_BITS 7

// bit counter marks within one serial word
`define TWS_CNT_W 4
`define TWS_CNT_BYTE 4'h8
`define TWS_CNT_ACK 4'h9

// self-timed write cycle
`define TWS_PROG_TIME_MS 5
`define TWS_CLK_KHZ 50000

`endif

// ### tws_eeprom.v
`timescale 1ns/1ps
`include "tws_consts.vh"

// Functional notes
// - sda may change only with scl low, except for start and stop.
// - sda falling while scl high is a start; start precedes every command.
// - sda rising while scl high is a stop; stop after read gives standby.
// - words are eight bits; device pulls sda low on the ninth clock.
// - standby at power-up and after stop once internal work is done.
// - device answers only when top five address bits match the type pattern.
// - two select bits compare with two strap pins; floating strap reads low.
// - eighth address bit high starts a read, low starts a write.
// - match gives acknowledge; mismatch gives none and returns to standby.
// - write-protect high blocks writes to the whole array.
// - byte write is device address, two address bytes, one data byte, stop.
// - during the internal write cycle inputs are ignored and nothing answers.
// - page write takes up to 64 bytes, each acknowledged, closed by stop.
// - page write increments low six address bits only, wrapping inside page.
// - more than 64 bytes wrap and overwrite earlier bytes of the page.
// - polling gets acknowledge only after the write cycle has finished.
// - address counter holds last address plus one while powered.
// - reads wrap from the last byte of memory to the first.
// - current read sends byte at counter; controller nacks then stops.
// - sequential read sends next byte on each controller acknowledge.
// - internal write cycle lasts at most five milliseconds from the stop; here it runs at least PROG_CYCLES clocks, longer while the array stalls.
module tws_eeprom #(
    parameter integer PROG_CYCLES = `TWS_PROG_TIME_MS * `TWS_CLK_KHZ
) (
    input wire clk,
    input wire reset,
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_n,
    input wire select_strap_high,
    input wire select_strap_low,
    input wire write_protect,
    output reg standby,
    output reg write_busy,
    output reg [`TWS_ADDR_W-1:0] fetch_addr,
    input wire [7:0] fetch_data,
    output reg prog_valid,
    output reg [`TWS_ADDR_W-1:0] prog_addr,
    output reg [7:0] prog_data,
    input wire prog_ready
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_DEV = 3'h1;
localparam [2:0] ST_AHI = 3'h2;
localparam [2:0] ST_ALO = 3'h3;
localparam [2:0] ST_WDATA = 3'h4;
localparam [2:0] ST_READ = 3'h5;
localparam [2:0] ST_PROG = 3'h6;

function [`TWS_ADDR_W-1:0] page_inc;
    input [`TWS_ADDR_W-1:0] a;
    begin
        page_inc = {a[`TWS_ADDR_W-1:`TWS_PAGE_W], a[`TWS_PAGE_W-1:0] + 6'h01};
    end
endfunction

function dev_match;
    input [7:0] w;
    input sel_hi;
    input sel_lo;
    begin
        dev_match = (w[`TWS_TYPE_MSB:`TWS_TYPE_LSB] == `TWS_TYPE_CODE) &&
                    (w[`TWS_SEL_HIGH_BIT] == sel_hi) && (w[`TWS_SEL_LOW_BIT] == sel_lo);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers; stage 0 feeds only stage 1, stage 2 is the edge history

reg [2:0] scl_q;
reg [2:0] sda_q;
reg [1:0] hi_q;
reg [1:0] lo_q;
reg [1:0] wp_q;

always @(posedge clk) begin
    if (reset) begin
        scl_q <= 3'h7;
        sda_q <= 3'h7;
        hi_q <= 2'h0;
        lo_q <= 2'h0;
        wp_q <= 2'h0;
    end else begin
        scl_q <= {scl_q[1:0], scl};
        sda_q <= {sda_q[1:0], sda_in};
        hi_q <= {hi_q[0], select_strap_high};
        lo_q <= {lo_q[0], select_strap_low};
        wp_q <= {wp_q[0], write_protect};
    end
end

wire scl_rise = scl_q[1] & ~scl_q[2];
wire scl_fall = ~scl_q[1] & scl_q[2];
wire start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
wire stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

////////////////////////////////////////////////////////////////////////////////
// serial engine and write cycle

reg [2:0] state;
reg [`TWS_CNT_W-1:0] cnt;
reg [7:0] shreg;
reg [63:0] page_valid;
reg [6:0] drain_idx;
reg [31:0] prog_cnt;
reg [7:0] page_buf [0:63];
reg skid_valid;
reg [`TWS_ADDR_W-1:0] skid_addr;
reg [7:0] skid_data;

wire page_we = scl_fall && (cnt == `TWS_CNT_BYTE) && (state == ST_WDATA);
wire drain_live = (state == ST_PROG) && (drain_idx < `TWS_PAGE_BYTES);
wire drain_hit = drain_live && page_valid[drain_idx[5:0]];
// skid entry empty is the ready toward the drain walker
wire push = drain_hit && !skid_valid;
wire [`TWS_ADDR_W-1:0] push_addr = {fetch_addr[`TWS_ADDR_W-1:`TWS_PAGE_W], drain_idx[5:0]};
wire prog_time_done = (prog_cnt >= PROG_CYCLES - 1);

// latched page bytes; a later byte at the same slot simply replaces the earlier
always @(posedge clk) begin
    if (page_we) begin
        page_buf[fetch_addr[`TWS_PAGE_W-1:0]] <= shreg;
    end
end

always @(posedge clk) begin
    if (reset) begin
        state <= ST_IDLE;
        cnt <= {`TWS_CNT_W{1'b0}};
        shreg <= 8'h00;
        sda_oe_n <= 1'b1;
        fetch_addr <= {`TWS_ADDR_W{1'b0}};
        page_valid <= 64'h0;
        drain_idx <= 7'h00;
        prog_cnt <= 32'h0;
    end else if (state == ST_PROG) begin
        // bus stays deaf here, so polling sees no acknowledge
        sda_oe_n <= 1'b1;
        if (!prog_time_done) begin
            prog_cnt <= prog_cnt + 32'h1;
        end
        if (drain_live && (!page_valid[drain_idx[5:0]] || !skid_valid)) begin
            drain_idx <= drain_idx + 7'h01;
        end
        if (prog_time_done && !drain_live && !skid_valid && !prog_valid) begin
            state <= ST_IDLE;
            page_valid <= 64'h0;
        end
    end else if (start_det) begin
        // a start from any state except ST_PROG resynchronises, which is what bus recovery needs
        state <= ST_DEV;
        cnt <= {`TWS_CNT_W{1'b0}};
        sda_oe_n <= 1'b1;
        page_valid <= 64'h0;
    end else if (stop_det) begin
        sda_oe_n <= 1'b1;
        if (state == ST_WDATA && page_valid != 64'h0 && !wp_q[1]) begin
            state <= ST_PROG;
            drain_idx <= 7'h00;
            prog_cnt <= 32'h0;
        end else begin
            // write-protected or read sequences go straight to standby
            state <= ST_IDLE;
        end
    end else if (state != ST_IDLE) begin
        if (scl_rise) begin
            if (cnt < `TWS_CNT_BYTE) begin
                if (state != ST_READ) begin
                    shreg <= {shreg[6:0], sda_q[1]};
                end
                cnt <= cnt + 4'h1;
            end else if (cnt == `TWS_CNT_BYTE) begin
                cnt <= `TWS_CNT_ACK;
                if (state == ST_READ && sda_q[1]) begin
                    state <= ST_IDLE;
                end
            end
        end else if (scl_fall) begin
            if (cnt == `TWS_CNT_BYTE) begin
                case (state)
                    ST_DEV: begin
                        if (dev_match(shreg, hi_q[1], lo_q[1])) begin
                            sda_oe_n <= 1'b0;
                            state <= shreg[`TWS_RW_BIT] ? ST_READ : ST_AHI;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_AHI: begin
                        fetch_addr[`TWS_ADDR_W-1:8] <= shreg[`TWS_HI_BYTE_BITS-1:0];
                        sda_oe_n <= 1'b0;
                        state <= ST_ALO;
                    end
                    ST_ALO: begin
                        // a repeated start after this point is the random-read dummy write
                        fetch_addr[7:0] <= shreg;
                        sda_oe_n <= 1'b0;
                        state <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        page_valid[fetch_addr[`TWS_PAGE_W-1:0]] <= 1'b1;
                        fetch_addr <= page_inc(fetch_addr);
                        sda_oe_n <= 1'b0;
                    end
                    ST_READ: begin
                        sda_oe_n <= 1'b1;
                    end
                    default: begin
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end else if (cnt == `TWS_CNT_ACK) begin
                cnt <= {`TWS_CNT_W{1'b0}};
                if (state == ST_READ) begin
                    shreg <= fetch_data;
                    sda_oe_n <= fetch_data[7];
                    fetch_addr <= fetch_addr + 15'h0001;
                end else begin
                    sda_oe_n <= 1'b1;
                end
            end else if (state == ST_READ && cnt != {`TWS_CNT_W{1'b0}}) begin
                sda_oe_n <= shreg[6];
                shreg <= {shreg[6:0], 1'b0};
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// two-entry output buffer toward the array: output stage plus skid stage

always @(posedge clk) begin
    if (reset) begin
        prog_valid <= 1'b0;
        prog_addr <= {`TWS_ADDR_W{1'b0}};
        prog_data <= 8'h00;
        skid_valid <= 1'b0;
        skid_addr <= {`TWS_ADDR_W{1'b0}};
        skid_data <= 8'h00;
    end else if (!prog_valid || prog_ready) begin
        if (skid_valid) begin
            prog_valid <= 1'b1;
            prog_addr <= skid_addr;
            prog_data <= skid_data;
            skid_valid <= 1'b0;
        end else if (push) begin
            prog_valid <= 1'b1;
            prog_addr <= push_addr;
            prog_data <= page_buf[drain_idx[5:0]];
        end else begin
            prog_valid <= 1'b0;
        end
    end else if (push) begin
        // array stalled: park the byte so the drain walker can stop without loss
        skid_valid <= 1'b1;
        skid_addr <= push_addr;
        skid_data <= page_buf[drain_idx[5:0]];
    end
end

////////////////////////////////////////////////////////////////////////////////
// status

always @(posedge clk) begin
    if (reset) begin
        sda_out <= 1'b0;
        standby <= 1'b1;
        write_busy <= 1'b0;
    end else begin
        // open drain: the driven level is always low, only the enable moves
        sda_out <= 1'b0;
        standby <= (state == ST_IDLE);
        write_busy <= (state == ST_PROG);
    end
end

endmodule

// ### tws_checker.sv
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_checker #(
    parameter integer PROG_CYCLES = `TWS_PROG_TIME_MS * `TWS_CLK_KHZ
) (
    input logic clk,
    input logic reset,
    input logic scl,
    input logic sda_oe_n,
    input logic write_protect,
    input logic standby,
    input logic write_busy,
    input logic prog_valid,
    input logic [`TWS_ADDR_W-1:0] prog_addr,
    input logic [7:0] prog_data,
    input logic prog_ready
);
    int busy_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    always @(posedge clk) begin
        busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    end
    a_drive_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
        else $error("sda drive moved while scl high");
    a_busy_silent: assert property (write_busy |-> sda_oe_n)
        else $error("device answered during write cycle");
    a_prog_in_busy: assert property (prog_valid |-> write_busy)
        else $error("program request outside write cycle");
    a_prog_held: assert property (prog_valid && !prog_ready |=> prog_valid && $stable({prog_addr, prog_data}))
        else $error("program request dropped before taken");
    a_page_row: assert property (prog_valid && $past(prog_valid) |-> prog_addr[14:6] == $past(prog_addr[14:6]))
        else $error("page write left its page");
    a_wp_blocks: assert property (write_protect && $past(write_protect, 8) |-> !$rose(write_busy))
        else $error("write cycle under write protect");
    a_prog_time: assert property ($fell(write_busy) |-> busy_cnt >= PROG_CYCLES - 8 && busy_cnt <= PROG_CYCLES + 200)
        else $error("write cycle length out of range");
    a_idle_after: assert property ($fell(write_busy) |-> ##[0:2] standby)
        else $error("no standby after write cycle");
    c_stall: cover property (prog_valid && !prog_ready);
    c_write: cover property ($rose(write_busy));
    c_ack: cover property ($fell(sda_oe_n));
endmodule
bind tws_eeprom tws_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clk(clk), .reset(reset), .scl(scl),
    .sda_oe_n(sda_oe_n), .write_protect(write_protect), .standby(standby), .write_busy(write_busy),
    .prog_valid(prog_valid), .prog_addr(prog_addr), .prog_data(prog_data), .prog_ready(prog_ready));

// ### tws_master.sv
`timescale 1ns/1ps
// bus controller: sda only pulled low or released, the pull-up makes the high level
module tws_master (
    input wire clk,
    input wire sda_bus,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic xfer(input logic b, output logic r);
        // one bit is eight clk: low for four, high for four
        @(posedge clk) sda_low <= ~b;
        repeat (3) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        r = sda_bus;
        scl <= 1'b0;
    endtask
    // go high gives a start, low a stop; sda moves one clk after scl fell
    task automatic frame(input logic go);
        @(posedge clk) sda_low <= ~go;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_low <= go;
        repeat (4) @(posedge clk);
        scl <= ~go;
    endtask
    task automatic word(input logic [7:0] d, input logic n9, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], q[i]);
        end
        xfer(n9, r);
        ack = ~r;
    endtask
    task automatic recover;
        logic r;
        r = 1'b0;
        for (int i = 0; i < 9 && !r; i++) begin
            xfer(1'b1, r);
        end
        frame(1'b1);
    endtask
endmodule

// ### tws_eeprom_tb.sv
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_eeprom_tb;
    logic clk = 1'b0;
    logic reset;
    logic write_protect;
    logic prog_ready;
    logic [1:0] strap;
    logic scl, sda_low, sda_out, sda_oe_n, standby, write_busy, prog_valid, ack;
    logic [`TWS_ADDR_W-1:0] fetch_addr, prog_addr;
    logic [7:0] prog_data, q;
    logic [7:0] mem [0:32767];
    logic [7:0] exp_mem [0:32767];
    logic [10:0] rows [9] = '{11'h5a4, 11'h4a0, 11'h4a6, 11'h3a2, 11'h7a7, 11'h020, 11'h0b0, 11'h1a1, 11'h5a5};
    int bad_count = 0;
    int samples_checked = 0;
    int ticks = 0;
    int ptr = 0;
    wire sda = ~sda_low & (sda_oe_n | sda_out);
    always #10 clk = ~clk;
    tws_eeprom #(.PROG_CYCLES(200)) dut_u (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .select_strap_high(strap[1]), .select_strap_low(strap[0]),
        .write_protect(write_protect), .standby(standby), .write_busy(write_busy), .fetch_addr(fetch_addr),
        .fetch_data(mem[fetch_addr]), .prog_valid(prog_valid), .prog_addr(prog_addr),
        .prog_data(prog_data), .prog_ready(prog_ready));
    tws_master m_u (.clk(clk), .sda_bus(sda), .scl(scl), .sda_low(sda_low));
    // array stalls half the time so the program buffer fills
    always @(posedge clk) begin
        ticks <= ticks + 1;
        prog_ready <= ticks[4];
        if (prog_valid && prog_ready)
            mem[prog_addr] <= prog_data;
        if (ticks == 60000) begin
            bad_count++;
            conclude;
        end
    end
    ////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
        samples_checked++;
        if (got !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic xw(input logic [7:0] d);
        m_u.word(d, 1'b1, q, ack);
        check("ack", 1, ack);
    endtask
    task automatic point(input logic [14:0] a);
        m_u.frame(1'b1);
        xw(8'ha4);
        // top bit of the high address byte is a don't-care, so send it set
        xw({1'b1, a[14:8]});
        xw(a[7:0]);
    endtask
    task automatic rd(input logic last, input logic [7:0] e);
        m_u.word(8'hff, last, q, ack);
        check("rdata", e, q);
    endtask
    task automatic settle;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 400 && write_busy; i++) @(posedge clk);
        check("busy", 0, write_busy);
    endtask
    initial begin
        reset = 1'b1;
        write_protect = 1'b0;
        strap = 2'b10;
        for (int i = 0; i < 32768; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
            exp_mem[i] = mem[i];
        end
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check("standby", 1, standby);
        foreach (rows[i]) begin
            @(posedge clk) strap <= rows[i][10:9];
            m_u.frame(1'b1);
            m_u.word(rows[i][7:0], 1'b1, q, ack);
            check("match", rows[i][8], ack);
            if (ack && rows[i][0]) begin
                rd(1'b1, exp_mem[ptr]);
                ptr++;
            end
            m_u.frame(1'b0);
        end
        point(15'h013e);
        for (int i = 0; i < 67; i++) begin
            xw(8'h30 + i[7:0]);
            exp_mem[256 + ((62 + i) % 64)] = 8'h30 + i[7:0];
        end
        m_u.frame(1'b0);
        m_u.frame(1'b1);
        m_u.word(8'ha4, 1'b1, q, ack);
        check("poll", 0, ack);
        m_u.frame(1'b0);
        settle;
        for (int i = 256; i < 320; i++) check("page", exp_mem[i], mem[i]);
        check("counter", 15'h0101, fetch_addr);
        m_u.frame(1'b1);
        xw(8'ha5);
        rd(1'b1, exp_mem[257]);
        m_u.frame(1'b0);
        point(15'h7ffe);
        m_u.frame(1'b1);
        xw(8'ha5);
        rd(1'b0, exp_mem[32766]);
        rd(1'b0, exp_mem[32767]);
        rd(1'b1, exp_mem[0]);
        m_u.frame(1'b0);
        check("standby", 1, standby);
        for (int w = 1; w >= 0; w--) begin
            @(posedge clk) write_protect <= w[0];
            point(15'h0005);
            xw(8'hee);
            m_u.frame(1'b0);
            if (w == 0) exp_mem[5] = 8'hee;
            settle;
            check("byte", exp_mem[5], mem[5]);
        end
        m_u.frame(1'b1);
        xw(8'ha4);
        repeat (3) m_u.xfer(1'b0, q[0]);
        m_u.recover;
        m_u.frame(1'b0);
        // stop is seen late through the synchronisers; let standby settle
        repeat (2) @(posedge clk);
        check("standby", 1, standby);
        @(posedge clk) reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        check("counter", 0, fetch_addr);
        conclude;
    end
endmodule
